// *** osc_guard_pkg.sv ***
package osc_guard_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_OSC      = 8'h1A;
  localparam logic [7:0] IDX_GUARD    = 8'h1B;
  localparam logic [7:0] IDX_TEST     = 8'h1C;
  localparam logic [7:0] IDX_VREG     = 8'h1D;
  localparam logic [7:0] IDX_OSC2     = 8'h1E;
  localparam logic [7:0] IDX_STATUS   = 8'h1F;
  localparam logic [7:0] ADDR_OSC     = {IDX_OSC[5:0], 2'b00};
  localparam logic [7:0] ADDR_GUARD   = {IDX_GUARD[5:0], 2'b00};
  localparam logic [7:0] ADDR_TEST    = {IDX_TEST[5:0], 2'b00};
  localparam logic [7:0] ADDR_VREG    = {IDX_VREG[5:0], 2'b00};
  localparam logic [7:0] ADDR_OSC2    = {IDX_OSC2[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS  = {IDX_STATUS[5:0], 2'b00};

  // Field positions
  localparam int unsigned OSC_ENABLE_BIT   = 7;
  localparam int unsigned OSC2_MONRST_BIT  = 1;
  localparam int unsigned OSC2_SWING_BIT   = 0;
  localparam int unsigned VREG_HIGHV_BIT   = 7;
  localparam int unsigned VREG_EXT_BIT     = 1;
  localparam int unsigned VREG_INT_BIT     = 0;
  localparam int unsigned STAT_UP_BIT      = 0;
  localparam int unsigned STAT_LOCK_BIT    = 1;

  // Key and reset values
  localparam logic [7:0] GUARD_KEY        = 8'h26;
  localparam logic       GUARD_RESET      = 1'b0;
  localparam logic [7:0] TEST_RESET       = 8'h00;
  localparam logic [7:0] VREG_RESET       = 8'h01;
  localparam logic [1:0] OSC2_RESET       = 2'b00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  // Status inputs from the analog side
  typedef struct packed {
    logic pll_locked;
    logic osc_stable;
    logic osc_lost;
  } analog_status_t;

  // Controls toward the oscillator and regulator
  typedef struct packed {
    logic crystal_enable;
    logic monitor_enable;
    logic qualify_by_pll;
    logic ref_from_crystal;
    logic pins_owned;
    logic monitor_reset_enable;
    logic swing_full;
    logic regulator_high_voltage;
    logic external_transistor;
    logic internal_transistor;
  } osc_ctrl_t;

endpackage : osc_guard_pkg

// *** osc_protect_vreg_config.sv ***
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Oscillator registers writable only unguarded, PLL-sourced.
// - Oscillator write clears lock and up flags.
// - Disabled crystal: reference from internal oscillator.
// - Enabled crystal: monitor, qualify, divided reference.
// - Enabling crystal claims pins until reset.
// - Monitor reset on loss when enabled.
// - Up flag set on stable oscillation while crystal on.
// - Key 0x26 clears guard, others set.
// - Guard blocks clock configuration register writes.
// - Test register written only in special mode.
// - Regulator written once normally, freely special.
// - Regulator write needs exactly one transistor.
// - Regulator bit 7 selects 5 volt.
// - Bit 1 external, bit 0 internal transistor.
// - Monitor reset enable frozen while crystal on.
// - Swing select frozen while on; upper zero.
// - Reference is crystal over divider plus one.
module osc_protect_vreg_config #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_n_i,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]            s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]            s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  // Clock system context
  input  wire logic                         pll_bus_source_select_i,
  input  wire logic                         special_mode_i,
  input  wire logic [3:0]                   reference_divider_i,
  input  osc_guard_pkg::analog_status_t     analog_status_i,
  // Clock ticks in the core domain
  input  wire logic                         crystal_tick_i,
  input  wire logic                         internal_ref_tick_i,
  // Outputs to the clock system
  output logic                              pll_reference_tick_o,
  output logic                              write_guard_bit_o,
  output logic                              crystal_up_flag_o,
  output logic                              pll_lock_flag_o,
  output logic                              monitor_reset_o,
  output osc_guard_pkg::osc_ctrl_t          osc_ctrl_o
);

  // Register state
  logic       crystal_enable_q, crystal_enable_d;
  logic       pins_owned_q, pins_owned_d;
  logic       monrst_en_q, monrst_en_d;
  logic       swing_q, swing_d;
  logic       guard_q, guard_d;
  logic [7:0] test_q, test_d;
  logic [7:0] vreg_q, vreg_d;
  logic       vreg_once_q, vreg_once_d;
  logic       up_q, up_d;
  logic       lock_q, lock_d;
  logic       stable_q, locked_q;
  logic [3:0] div_cnt_q, div_cnt_d;
  logic       ref_tick_q, ref_tick_d;
  logic       monrst_q, monrst_d;
  // Bus state
  logic       bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic       rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  logic       wr_fire, rd_fire, lane0;
  logic [7:0] wbyte, waddr, raddr;
  logic       wr_osc, wr_osc2, wr_guard, wr_test, wr_vreg, wr_mapped;
  logic       osc_wr_ok, vreg_legal;

  // Write and read handshakes: both write channels taken together
  assign wr_fire         = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
  assign s_axi_awready_o = s_axi_wvalid_i & ~bvalid_q;
  assign s_axi_wready_o  = s_axi_awvalid_i & ~bvalid_q;
  assign rd_fire         = s_axi_arvalid_i & ~rvalid_q;
  assign s_axi_arready_o = ~rvalid_q;

  // Address decode
  assign waddr     = s_axi_awaddr_i[7:0];
  assign raddr     = s_axi_araddr_i[7:0];
  assign wbyte     = s_axi_wdata_i[7:0];
  assign lane0     = s_axi_wstrb_i[0];
  assign wr_osc    = wr_fire & lane0 & (waddr == osc_guard_pkg::ADDR_OSC);
  assign wr_osc2   = wr_fire & lane0 & (waddr == osc_guard_pkg::ADDR_OSC2);
  assign wr_guard  = wr_fire & lane0 & (waddr == osc_guard_pkg::ADDR_GUARD);
  assign wr_test   = wr_fire & lane0 & (waddr == osc_guard_pkg::ADDR_TEST);
  assign wr_vreg   = wr_fire & lane0 & (waddr == osc_guard_pkg::ADDR_VREG);
  assign wr_mapped = (waddr == osc_guard_pkg::ADDR_OSC) | (waddr == osc_guard_pkg::ADDR_OSC2) |
                     (waddr == osc_guard_pkg::ADDR_GUARD) | (waddr == osc_guard_pkg::ADDR_TEST) |
                     (waddr == osc_guard_pkg::ADDR_VREG) | (waddr == osc_guard_pkg::ADDR_STATUS);

  // Write permissions
  assign osc_wr_ok  = ~guard_q & pll_bus_source_select_i;
  assign vreg_legal = wbyte[osc_guard_pkg::VREG_EXT_BIT] ^
                      wbyte[osc_guard_pkg::VREG_INT_BIT];

  // Next state of the configuration registers
  always_comb begin
    crystal_enable_d = crystal_enable_q;
    pins_owned_d     = pins_owned_q;
    monrst_en_d      = monrst_en_q;
    swing_d          = swing_q;
    guard_d          = guard_q;
    test_d           = test_q;
    vreg_d           = vreg_q;
    vreg_once_d      = vreg_once_q;
    if (wr_osc && osc_wr_ok) begin
      crystal_enable_d = wbyte[osc_guard_pkg::OSC_ENABLE_BIT];
      if (wbyte[osc_guard_pkg::OSC_ENABLE_BIT]) begin
        pins_owned_d = 1'b1;
      end
    end
    if (wr_osc2 && osc_wr_ok && !crystal_enable_q) begin
      monrst_en_d = wbyte[osc_guard_pkg::OSC2_MONRST_BIT];
      swing_d     = wbyte[osc_guard_pkg::OSC2_SWING_BIT];
    end
    if (wr_guard) begin
      guard_d = (wbyte != osc_guard_pkg::GUARD_KEY);
    end
    if (wr_test && special_mode_i) begin
      test_d = wbyte;
    end
    if (wr_vreg && vreg_legal && (special_mode_i || !vreg_once_q)) begin
      vreg_d      = wbyte;
      vreg_once_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      crystal_enable_q <= 1'b0;
      pins_owned_q     <= 1'b0;
      monrst_en_q      <= osc_guard_pkg::OSC2_RESET[osc_guard_pkg::OSC2_MONRST_BIT];
      swing_q          <= osc_guard_pkg::OSC2_RESET[osc_guard_pkg::OSC2_SWING_BIT];
      guard_q          <= osc_guard_pkg::GUARD_RESET;
      test_q           <= osc_guard_pkg::TEST_RESET;
      vreg_q           <= osc_guard_pkg::VREG_RESET;
      vreg_once_q      <= 1'b0;
    end else begin
      crystal_enable_q <= crystal_enable_d;
      pins_owned_q     <= pins_owned_d;
      monrst_en_q      <= monrst_en_d;
      swing_q          <= swing_d;
      guard_q          <= guard_d;
      test_q           <= test_d;
      vreg_q           <= vreg_d;
      vreg_once_q      <= vreg_once_d;
    end
  end

  // Status flags: set on a rising stable (crystal on) or locked level, cleared by an oscillator write
  always_comb begin
    up_d   = up_q | (analog_status_i.osc_stable & ~stable_q);
    lock_d = (lock_q | (analog_status_i.pll_locked & ~locked_q)) & analog_status_i.pll_locked;
    if (wr_osc && osc_wr_ok) begin
      up_d   = 1'b0;
      lock_d = 1'b0;
    end
    if (!crystal_enable_q) begin
      up_d = 1'b0;
    end
  end

  // Reference divider and monitor reset
  always_comb begin
    div_cnt_d  = div_cnt_q;
    ref_tick_d = internal_ref_tick_i;
    monrst_d   = crystal_enable_q & monrst_en_q & analog_status_i.osc_lost;
    if (crystal_enable_q) begin
      ref_tick_d = 1'b0;
      if (crystal_tick_i) begin
        if (div_cnt_q >= reference_divider_i) begin
          div_cnt_d  = 4'h0;
          ref_tick_d = 1'b1;
        end else begin
          div_cnt_d = div_cnt_q + 4'h1;
        end
      end
    end else begin
      div_cnt_d = 4'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      up_q       <= 1'b0;
      lock_q     <= 1'b0;
      stable_q   <= 1'b0;
      locked_q   <= 1'b0;
      div_cnt_q  <= 4'h0;
      ref_tick_q <= 1'b0;
      monrst_q   <= 1'b0;
    end else begin
      up_q       <= up_d;
      lock_q     <= lock_d;
      stable_q   <= analog_status_i.osc_stable;
      locked_q   <= analog_status_i.pll_locked;
      div_cnt_q  <= div_cnt_d;
      ref_tick_q <= ref_tick_d;
      monrst_q   <= monrst_d;
    end
  end

  // Bus responses and read mux
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d  = wr_mapped ? osc_guard_pkg::RESP_OKAY : osc_guard_pkg::RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = osc_guard_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (raddr)
        osc_guard_pkg::ADDR_OSC: begin
          rdata_d[osc_guard_pkg::OSC_ENABLE_BIT] = crystal_enable_q;
        end
        osc_guard_pkg::ADDR_GUARD: begin
          rdata_d[0] = guard_q;
        end
        osc_guard_pkg::ADDR_TEST: begin
          rdata_d[7:0] = test_q;
        end
        osc_guard_pkg::ADDR_VREG: begin
          rdata_d[7:0] = vreg_q;
        end
        osc_guard_pkg::ADDR_OSC2: begin
          rdata_d[osc_guard_pkg::OSC2_MONRST_BIT] = monrst_en_q;
          rdata_d[osc_guard_pkg::OSC2_SWING_BIT]  = swing_q;
        end
        osc_guard_pkg::ADDR_STATUS: begin
          rdata_d[osc_guard_pkg::STAT_UP_BIT]   = up_q;
          rdata_d[osc_guard_pkg::STAT_LOCK_BIT] = lock_q;
        end
        default: begin
          rresp_d = osc_guard_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= osc_guard_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= osc_guard_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // Output drive
  assign s_axi_bvalid_o       = bvalid_q;
  assign s_axi_bresp_o        = bresp_q;
  assign s_axi_rvalid_o       = rvalid_q;
  assign s_axi_rresp_o        = rresp_q;
  assign s_axi_rdata_o        = rdata_q;
  assign pll_reference_tick_o = ref_tick_q;
  assign write_guard_bit_o    = guard_q;
  assign crystal_up_flag_o    = up_q;
  assign pll_lock_flag_o      = lock_q;
  assign monitor_reset_o      = monrst_q;

  // Control bundle toward the analog blocks
  always_comb begin
    osc_ctrl_o.crystal_enable         = crystal_enable_q;
    osc_ctrl_o.monitor_enable         = crystal_enable_q;
    osc_ctrl_o.qualify_by_pll         = crystal_enable_q;
    osc_ctrl_o.ref_from_crystal       = crystal_enable_q;
    osc_ctrl_o.pins_owned             = pins_owned_q;
    osc_ctrl_o.monitor_reset_enable   = monrst_en_q;
    osc_ctrl_o.swing_full             = swing_q;
    osc_ctrl_o.regulator_high_voltage = vreg_q[osc_guard_pkg::VREG_HIGHV_BIT];
    osc_ctrl_o.external_transistor    = vreg_q[osc_guard_pkg::VREG_EXT_BIT];
    osc_ctrl_o.internal_transistor    = vreg_q[osc_guard_pkg::VREG_INT_BIT];
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_guard_key_clears: assert property (
    wr_guard && wbyte == osc_guard_pkg::GUARD_KEY |=> !write_guard_bit_o)
    else $error("guard not cleared by key");
  a_guard_other_sets: assert property (
    wr_guard && wbyte != osc_guard_pkg::GUARD_KEY |=> write_guard_bit_o)
    else $error("guard not set by other value");
  a_osc_write_blocked: assert property (
    wr_osc && (guard_q || !pll_bus_source_select_i) |=> $stable(crystal_enable_q))
    else $error("blocked oscillator write took effect");
  a_status_cleared: assert property (
    wr_osc && osc_wr_ok |=> !crystal_up_flag_o && !pll_lock_flag_o)
    else $error("status not cleared by oscillator write");
  a_pins_stay_owned: assert property (
    osc_ctrl_o.pins_owned |=> osc_ctrl_o.pins_owned)
    else $error("crystal pins released before reset");
  a_monrst_frozen: assert property (
    wr_osc2 && crystal_enable_q |=> $stable(monrst_en_q) && $stable(swing_q))
    else $error("oscillator two changed while crystal on");
  a_vreg_illegal_kept: assert property (
    wr_vreg && !vreg_legal |=> $stable(vreg_q) && $stable(vreg_once_q))
    else $error("illegal regulator write took effect");
  a_vreg_write_once: assert property (
    wr_vreg && vreg_once_q && !special_mode_i |=> $stable(vreg_q))
    else $error("second regulator write in normal mode");
  a_test_mode_only: assert property (
    wr_test && !special_mode_i |=> $stable(test_q))
    else $error("test register written outside special mode");
  a_ref_internal: assert property (
    !crystal_enable_q |=> pll_reference_tick_o == $past(internal_ref_tick_i))
    else $error("reference not from internal oscillator");
  a_monitor_reset: assert property (
    crystal_enable_q && monrst_en_q && analog_status_i.osc_lost |=> monitor_reset_o)
    else $error("monitor reset missing on loss");
  a_write_answer: assert property (
    wr_fire |=> s_axi_bvalid_o)
    else $error("write response missing");
  a_read_answer: assert property (
    rd_fire |=> s_axi_rvalid_o)
    else $error("read response missing");
  a_swing_frozen: assert property (
    wr_osc2 && crystal_enable_q |=> $stable(swing_q))
    else $error("swing select changed while crystal on");
  a_up_flag_set: assert property (
    crystal_enable_q && analog_status_i.osc_stable && !stable_q && !(wr_osc && osc_wr_ok)
    |=> crystal_up_flag_o)
    else $error("up flag not set on stable oscillation");

  c_crystal_on: cover property (wr_osc && osc_wr_ok && wbyte[osc_guard_pkg::OSC_ENABLE_BIT]);
  c_vreg_written: cover property (wr_vreg && vreg_legal && !vreg_once_q);
  c_guard_unlock: cover property (wr_guard ##1 !write_guard_bit_o);
  c_monitor_reset: cover property (monitor_reset_o);
  c_ref_divided: cover property (crystal_enable_q && reference_divider_i != 4'h0 &&
                                 pll_reference_tick_o);

endmodule : osc_protect_vreg_config

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and clock system context
  logic                           core_clk;
  logic                           reset_n;
  logic                           pll_sel;
  logic                           special;
  logic [3:0]                     ref_div;
  logic                           crystal_output_pin_tick;
  logic                           irc_tick;
  osc_guard_pkg::analog_status_t  ana;
  // Bus master side
  logic [7:0]                     awaddr;
  logic                           awvalid;
  logic [31:0]                    wdata;
  logic [3:0]                     wstrb;
  logic                           wvalid;
  logic                           bready;
  logic [7:0]                     araddr;
  logic                           arvalid;
  logic                           rready;
  // Design answers
  logic                           awready;
  logic                           wready;
  logic [1:0]                     bresp;
  logic                           bvalid;
  logic                           arready;
  logic [31:0]                    rdata;
  logic [1:0]                     rresp;
  logic                           rvalid;
  logic                           ref_tick;
  logic                           guard_bit;
  logic                           up_flag;
  logic                           lock_flag;
  logic                           mon_rst;
  osc_guard_pkg::osc_ctrl_t       ctrl;
  int                             fails;
  int                             check_count;
  // Register map and reset image, status last
  logic [7:0] addr_tab [6] = '{osc_guard_pkg::ADDR_OSC, osc_guard_pkg::ADDR_GUARD,
    osc_guard_pkg::ADDR_TEST, osc_guard_pkg::ADDR_VREG, osc_guard_pkg::ADDR_OSC2,
    osc_guard_pkg::ADDR_STATUS};
  logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

  osc_protect_vreg_config i_dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pll_bus_source_select_i(pll_sel), .special_mode_i(special),
    .reference_divider_i(ref_div), .analog_status_i(ana),
    .crystal_tick_i(crystal_output_pin_tick), .internal_ref_tick_i(irc_tick),
    .pll_reference_tick_o(ref_tick), .write_guard_bit_o(guard_bit),
    .crystal_up_flag_o(up_flag), .pll_lock_flag_o(lock_flag),
    .monitor_reset_o(mon_rst), .osc_ctrl_o(ctrl));

  // Free running 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Value comparison with mismatch report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write; payload held until its ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(negedge core_clk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge core_clk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(negedge core_clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : wr

  // Bus read with expected data and answer code
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    chk(rdata, {24'h000000, e});
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : rd

  // Pulses both reference sources n times and counts reference ticks
  task automatic pulses(input int n, input int exp);
    int cnt;
    cnt = 0;
    repeat (n) begin
      @(posedge core_clk); crystal_output_pin_tick <= 1'b1; irc_tick <= 1'b1;
      @(negedge core_clk); cnt += (ref_tick === 1'b1) ? 1 : 0;
      @(posedge core_clk); crystal_output_pin_tick <= 1'b0; irc_tick <= 1'b0;
      @(negedge core_clk); cnt += (ref_tick === 1'b1) ? 1 : 0;
    end
    repeat (2) begin @(negedge core_clk); cnt += (ref_tick === 1'b1) ? 1 : 0; end
    // Return on a rising edge so the next input change lands there
    @(posedge core_clk);
    chk(cnt, exp);
  endtask : pulses

  // Verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    end_sim();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0; pll_sel = 1'b0; special = 1'b0; ref_div = 4'h0;
    crystal_output_pin_tick = 1'b0; irc_tick = 1'b0; ana = '0; fails = 0; check_count = 0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    // Reset image and unmapped place
    for (int i = 0; i < 6; i++) rd(addr_tab[i], rst_tab[i], osc_guard_pkg::RESP_OKAY);
    chk({22'h0, ctrl}, {22'h0, 10'h001});
    rd(8'h00, 8'h00, osc_guard_pkg::RESP_SLVERR);
    wr(8'h00, 8'h26, osc_guard_pkg::RESP_SLVERR);
    $display("test reset done");
    // Bus source and guard
    wr(osc_guard_pkg::ADDR_OSC, 8'h80, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_OSC, 8'h00, osc_guard_pkg::RESP_OKAY);
    pll_sel <= 1'b1;
    wr(osc_guard_pkg::ADDR_GUARD, 8'h27, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_GUARD, 8'h01, osc_guard_pkg::RESP_OKAY);
    chk({31'h0, guard_bit}, 32'h1);
    wr(osc_guard_pkg::ADDR_OSC, 8'h80, osc_guard_pkg::RESP_OKAY);
    wr(osc_guard_pkg::ADDR_OSC2, 8'h03, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_OSC, 8'h00, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_OSC2, 8'h00, osc_guard_pkg::RESP_OKAY);
    wr(osc_guard_pkg::ADDR_GUARD, 8'h26, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_GUARD, 8'h00, osc_guard_pkg::RESP_OKAY);
    $display("test guard done");
    // Second oscillator register and internal reference
    wr(osc_guard_pkg::ADDR_OSC2, 8'hFF, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_OSC2, 8'h03, osc_guard_pkg::RESP_OKAY);
    pulses(4, 4);
    // Crystal enabled: controls, frozen bits, divided reference
    wr(osc_guard_pkg::ADDR_OSC, 8'h80, osc_guard_pkg::RESP_OKAY);
    chk({22'h0, ctrl}, {22'h0, 10'h3F9});
    wr(osc_guard_pkg::ADDR_OSC2, 8'h00, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_OSC2, 8'h03, osc_guard_pkg::RESP_OKAY);
    ref_div <= 4'hF;
    pulses(16, 1);
    ref_div <= 4'h2;
    pulses(6, 2);
    ana <= '{pll_locked: 1'b1, osc_stable: 1'b1, osc_lost: 1'b0};
    rd(osc_guard_pkg::ADDR_STATUS, 8'h03, osc_guard_pkg::RESP_OKAY);
    chk({31'h0, up_flag}, 32'h1);
    ana <= '{pll_locked: 1'b1, osc_stable: 1'b1, osc_lost: 1'b1};
    repeat (3) @(posedge core_clk);
    chk({31'h0, mon_rst}, 32'h1);
    ana <= '{pll_locked: 1'b1, osc_stable: 1'b1, osc_lost: 1'b0};
    wr(osc_guard_pkg::ADDR_OSC, 8'h80, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_STATUS, 8'h00, osc_guard_pkg::RESP_OKAY);
    chk({30'h0, up_flag, lock_flag}, 32'h0);
    wr(osc_guard_pkg::ADDR_OSC, 8'h00, osc_guard_pkg::RESP_OKAY);
    chk({30'h0, ctrl.crystal_enable, ctrl.pins_owned}, 32'h1);
    pulses(2, 2);
    $display("test crystal done");
    // Factory test register
    wr(osc_guard_pkg::ADDR_TEST, 8'h5A, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_TEST, 8'h00, osc_guard_pkg::RESP_OKAY);
    special <= 1'b1;
    wr(osc_guard_pkg::ADDR_TEST, 8'h5A, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_TEST, 8'h5A, osc_guard_pkg::RESP_OKAY);
    special <= 1'b0;
    $display("test factory done");
    // Regulator: illegal pairs, one-shot, special mode
    wr(osc_guard_pkg::ADDR_VREG, 8'h03, osc_guard_pkg::RESP_OKAY);
    wr(osc_guard_pkg::ADDR_VREG, 8'h80, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_VREG, 8'h01, osc_guard_pkg::RESP_OKAY);
    wr(osc_guard_pkg::ADDR_VREG, 8'h82, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_VREG, 8'h82, osc_guard_pkg::RESP_OKAY);
    chk({29'h0, ctrl[2:0]}, 32'h6);
    wr(osc_guard_pkg::ADDR_VREG, 8'h01, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_VREG, 8'h82, osc_guard_pkg::RESP_OKAY);
    special <= 1'b1;
    wr(osc_guard_pkg::ADDR_VREG, 8'h01, osc_guard_pkg::RESP_OKAY);
    chk({29'h0, ctrl[2:0]}, 32'h1);
    wr(osc_guard_pkg::ADDR_VREG, 8'h81, osc_guard_pkg::RESP_OKAY);
    rd(osc_guard_pkg::ADDR_VREG, 8'h81, osc_guard_pkg::RESP_OKAY);
    $display("test regulator done");
    end_sim();
  end
endmodule : tb_top
